// ==== shared/monitor_status_control_pkg.sv ====
// Constants shared by the monitor status and control register logic.
package monitor_status_control_pkg;

  // Register location and value after reset.
  localparam logic [7:0] STATUS_CONTROL_ADDR = 8'hE2;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;

  // Field positions inside the status and control register.
  localparam int PWM_FULL_OVERRIDE_BIT = 0;
  localparam int CLEAR_MODE_BIT = 1;
  localparam int INPUT4_AUTO_MASK_BIT = 2;
  localparam int INPUT5_AUTO_MASK_BIT = 3;
  localparam int TACH_EDGE_LSB = 4;
  localparam int TACH_EDGE_MSB = 5;
  localparam int HOST_FAULT_SUMMARY_BIT = 6;
  localparam int MGMT_CONTROLLER_FAULT_SUMMARY_BIT = 7;

  // Tachometer edge selection codes.
  typedef enum logic [1:0] {
    TACH_EDGE_EITHER = 2'b00,
    TACH_EDGE_RISING = 2'b01,
    TACH_EDGE_FALLING = 2'b10,
    TACH_EDGE_RESERVED = 2'b11
  } tach_edge_t;

endpackage

// ==== design/monitor_status_control_reg.sv ====
// Status and control register of the hardware monitor with its fault masking and alert logic.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Override bit set forces every fan PWM output to full duty.
// - Clear-mode set makes reads of management fault registers clear them.
// - Clear-mode zero leaves reads harmless; only writing one clears a bit.
// - Input-4 auto-mask set: an input-4 fault masks every other error event.
// - Management fault registers stay frozen until their input-4 fault flag clears.
// - Host fault registers stay frozen until their input-4 fault flag clears.
// - Input-5 auto-mask works the same, using input 5 and its flags.
// - Bits 5:4 pick tach edge: either, rising, falling; code 3 reserved.
// - Host summary bit reads one when any host fault bit is set.
// - Management summary bit reads one when any management fault bit is set.
// - Alert output asserts while management summary is set and alert is enabled.
// - Configuration lock freezes the clear-mode bit while i_config_lock is high.
module monitor_status_control_reg
  import monitor_status_control_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_config_lock,
  input wire logic i_alert_en,
  input wire logic i_host_err_any,
  input wire logic i_mgmt_err_any,
  input wire logic i_input4_event,
  input wire logic i_input5_event,
  input wire logic i_input4_fault_flag_mgmt,
  input wire logic i_input4_fault_flag_host,
  input wire logic i_input5_fault_flag_mgmt,
  input wire logic i_input5_fault_flag_host,
  output logic o_pwm_full_override,
  output logic o_mgmt_read_clears,
  output logic [1:0] o_tach_edge,
  output logic o_mgmt_record_block,
  output logic o_host_record_block,
  output logic o_alert
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------

  logic rst_sync1_r;
  logic rst_sync2_r;

  // Reset asserts at once and releases through two flip-flops.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end
    else
    begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  logic rst_b_int;
  assign rst_b_int = rst_sync2_r;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------

  // True when a strobe addresses this register.
  function automatic logic hits_reg(input logic strobe, input logic [7:0] addr);
    hits_reg = strobe && (addr == STATUS_CONTROL_ADDR);
  endfunction

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = hits_reg(i_reg_wr, i_reg_addr);
  assign rd_hit = hits_reg(i_reg_rd, i_reg_addr);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------

  logic override_r;
  logic override_nxt;
  logic clear_mode_r;
  logic clear_mode_nxt;
  logic am4_r;
  logic am4_nxt;
  logic am5_r;
  logic am5_nxt;
  tach_edge_t edge_r;
  tach_edge_t edge_nxt;

  // Writes load the writable fields; clear-mode holds while configuration is locked.
  always_comb
  begin
    override_nxt = override_r;
    clear_mode_nxt = clear_mode_r;
    am4_nxt = am4_r;
    am5_nxt = am5_r;
    edge_nxt = edge_r;
    if (wr_hit)
    begin
      override_nxt = i_reg_wdata[PWM_FULL_OVERRIDE_BIT];
      if (!i_config_lock)
      begin
        clear_mode_nxt = i_reg_wdata[CLEAR_MODE_BIT];
      end
      am4_nxt = i_reg_wdata[INPUT4_AUTO_MASK_BIT];
      am5_nxt = i_reg_wdata[INPUT5_AUTO_MASK_BIT];
      edge_nxt = tach_edge_t'(i_reg_wdata[TACH_EDGE_MSB:TACH_EDGE_LSB]);
    end
  end

  // Control fields take their reset values and then follow the next values.
  always_ff @(posedge i_clk or negedge rst_b_int)
  begin
    if (!rst_b_int)
    begin
      override_r <= STATUS_CONTROL_RESET[PWM_FULL_OVERRIDE_BIT];
      clear_mode_r <= STATUS_CONTROL_RESET[CLEAR_MODE_BIT];
      am4_r <= STATUS_CONTROL_RESET[INPUT4_AUTO_MASK_BIT];
      am5_r <= STATUS_CONTROL_RESET[INPUT5_AUTO_MASK_BIT];
      edge_r <= tach_edge_t'(STATUS_CONTROL_RESET[TACH_EDGE_MSB:TACH_EDGE_LSB]);
    end
    else
    begin
      override_r <= override_nxt;
      clear_mode_r <= clear_mode_nxt;
      am4_r <= am4_nxt;
      am5_r <= am5_nxt;
      edge_r <= edge_nxt;
    end
  end

  // Control fields drive the fan, tach and clear-mode logic directly.
  assign o_pwm_full_override = override_r;
  assign o_mgmt_read_clears = clear_mode_r;
  assign o_tach_edge = edge_r;

  // ----------------------------------------------------------------
  // Auto-mask of error recording
  // ----------------------------------------------------------------

  // A masking fault counts from its own event until the bank's fault flag clears.
  // The event term covers the cycle before the flag itself is seen set.
  assign o_mgmt_record_block = (am4_r && (i_input4_event || i_input4_fault_flag_mgmt))
                            || (am5_r && (i_input5_event || i_input5_fault_flag_mgmt));
  assign o_host_record_block = (am4_r && (i_input4_event || i_input4_fault_flag_host))
                            || (am5_r && (i_input5_event || i_input5_fault_flag_host));

  // ----------------------------------------------------------------
  // Read data and alert
  // ----------------------------------------------------------------

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic alert_r;
  logic alert_nxt;

  // Reads capture the fields and the live summary levels; the alert tracks the summary.
  always_comb
  begin
    rdata_nxt = rdata_r;
    rvalid_nxt = rd_hit;
    if (rd_hit)
    begin
      rdata_nxt = 8'h00;
      rdata_nxt[PWM_FULL_OVERRIDE_BIT] = override_r;
      rdata_nxt[CLEAR_MODE_BIT] = clear_mode_r;
      rdata_nxt[INPUT4_AUTO_MASK_BIT] = am4_r;
      rdata_nxt[INPUT5_AUTO_MASK_BIT] = am5_r;
      rdata_nxt[TACH_EDGE_MSB:TACH_EDGE_LSB] = edge_r;
      rdata_nxt[HOST_FAULT_SUMMARY_BIT] = i_host_err_any;
      rdata_nxt[MGMT_CONTROLLER_FAULT_SUMMARY_BIT] = i_mgmt_err_any;
    end
    alert_nxt = i_mgmt_err_any && i_alert_en;
  end

  // Read data and alert registers.
  always_ff @(posedge i_clk or negedge rst_b_int)
  begin
    if (!rst_b_int)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      alert_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      alert_r <= alert_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_alert = alert_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_b_int);

  // A write that sets the override bit.
  sequence seq_override_write;
    wr_hit && i_reg_wdata[PWM_FULL_OVERRIDE_BIT];
  endsequence

  // No further write arrives for two cycles.
  sequence seq_quiet_two;
    !wr_hit [*2];
  endsequence

  chk_pwm_override_holds: assert property (seq_override_write ##1 seq_quiet_two |-> o_pwm_full_override [*2])
    else $error("Override did not hold after being written.");

  chk_clear_mode_write: assert property (wr_hit && !i_config_lock
    |=> o_mgmt_read_clears == $past(i_reg_wdata[CLEAR_MODE_BIT]))
    else $error("Clear mode did not take the written value.");

  chk_clear_mode_locked: assert property (wr_hit && i_config_lock |=> $stable(o_mgmt_read_clears))
    else $error("Clear mode changed while locked.");

  chk_input4_mgmt_block: assert property (am4_r && i_input4_fault_flag_mgmt |-> o_mgmt_record_block)
    else $error("Management recording not blocked by input 4 fault.");

  chk_input4_host_block: assert property (am4_r && i_input4_event |-> o_host_record_block)
    else $error("Host recording not blocked by input 4 event.");

  chk_input5_release: assert property (!i_input5_fault_flag_host && !i_input5_event
    && !(am4_r && (i_input4_event || i_input4_fault_flag_host)) |-> !o_host_record_block)
    else $error("Host recording blocked with no masking fault.");

  chk_tach_edge_write: assert property (wr_hit
    |=> o_tach_edge == $past(i_reg_wdata[TACH_EDGE_MSB:TACH_EDGE_LSB]))
    else $error("Tach edge field did not take the written value.");

  chk_summary_read: assert property (rd_hit |=> o_reg_rvalid
    && o_reg_rdata[HOST_FAULT_SUMMARY_BIT] == $past(i_host_err_any)
    && o_reg_rdata[MGMT_CONTROLLER_FAULT_SUMMARY_BIT] == $past(i_mgmt_err_any))
    else $error("Summary bits did not reflect the fault banks.");

  chk_alert_follow: assert property (i_mgmt_err_any && i_alert_en |=> o_alert)
    else $error("Alert not asserted for a management fault.");

  chk_alert_quiet: assert property (!i_alert_en |=> !o_alert)
    else $error("Alert asserted while disabled.");

  // The alert falls once the management summary is clear.
  chk_alert_drop: assert property (!i_mgmt_err_any |=> !o_alert)
    else $error("Alert stayed high with no management fault.");

  // Writing zero to the override bit returns the fans to automatic control.
  chk_override_clear: assert property (wr_hit && !i_reg_wdata[PWM_FULL_OVERRIDE_BIT] |=> !o_pwm_full_override)
    else $error("Override stayed set after a zero was written.");

  // Without a write the fan and tach controls keep their values.
  chk_fields_hold: assert property (!wr_hit |=> $stable(o_tach_edge) && $stable(o_pwm_full_override))
    else $error("Control fields changed without a write.");

  // A read returns the override and tach edge fields as they stood at the strobe.
  chk_read_fields: assert property (rd_hit |=> o_reg_rdata[TACH_EDGE_MSB:TACH_EDGE_LSB] == $past(o_tach_edge)
    && o_reg_rdata[PWM_FULL_OVERRIDE_BIT] == $past(o_pwm_full_override))
    else $error("Read data did not match the control fields.");

  // A read returns the clear-mode selection as it stood at the strobe.
  chk_read_clear_mode: assert property (rd_hit |=> o_reg_rdata[CLEAR_MODE_BIT] == $past(o_mgmt_read_clears))
    else $error("Read data did not match the clear mode.");

  // An input-5 fault blocks management recording while its auto-mask is enabled.
  chk_input5_mgmt_block: assert property (am5_r && (i_input5_event || i_input5_fault_flag_mgmt)
    |-> o_mgmt_record_block)
    else $error("Management recording not blocked by input 5 fault.");

  // The host input-5 flag keeps host recording blocked.
  chk_input5_host_block: assert property (am5_r && i_input5_fault_flag_host |-> o_host_record_block)
    else $error("Host recording not blocked by input 5 flag.");

  // Management recording resumes once no masking fault remains.
  chk_input4_mgmt_release: assert property (!i_input4_event && !i_input4_fault_flag_mgmt
    && !(am5_r && (i_input5_event || i_input5_fault_flag_mgmt)) |-> !o_mgmt_record_block)
    else $error("Management recording blocked with no masking fault.");

  // With both auto-mask enables clear nothing is ever blocked.
  chk_mask_disabled: assert property (!am4_r && !am5_r |-> !o_mgmt_record_block && !o_host_record_block)
    else $error("Recording blocked while auto-mask is disabled.");

endmodule

`default_nettype wire

// ==== verif/monitor_status_control_reg_tb.sv ====
// Self-checking testbench for the monitor status and control register.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module monitor_status_control_reg_tb;
  import monitor_status_control_pkg::*;
  typedef struct {logic [7:0] wd; logic host; logic mgmt; logic [7:0] exp;} row_t;
  localparam int LIMIT = 1000;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_config_lock = 1'b0, i_alert_en = 1'b0;
  logic i_host_err_any = 1'b0, i_mgmt_err_any = 1'b0, i_input4_event = 1'b0, i_input5_event = 1'b0;
  logic i_input4_fault_flag_mgmt = 1'b0, i_input4_fault_flag_host = 1'b0;
  logic i_input5_fault_flag_mgmt = 1'b0, i_input5_fault_flag_host = 1'b0;
  logic o_reg_rvalid, o_pwm_full_override, o_mgmt_read_clears, o_mgmt_record_block, o_host_record_block, o_alert;
  logic [1:0] o_tach_edge;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  // Ordinary cases: written byte, summary inputs and the byte expected on read.
  row_t rows [8] = '{'{8'hC1, 1'b0, 1'b0, 8'h01}, '{8'h02, 1'b0, 1'b0, 8'h02}, '{8'h04, 1'b1, 1'b0, 8'h44},
    '{8'h08, 1'b0, 1'b1, 8'h88}, '{8'h10, 1'b0, 1'b0, 8'h10}, '{8'h20, 1'b0, 1'b0, 8'h20},
    '{8'h15, 1'b0, 1'b0, 8'h15}, '{8'h2F, 1'b1, 1'b1, 8'hEF}};

  monitor_status_control_reg u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_config_lock(i_config_lock), .i_alert_en(i_alert_en), .i_host_err_any(i_host_err_any),
    .i_mgmt_err_any(i_mgmt_err_any), .i_input4_event(i_input4_event), .i_input5_event(i_input5_event),
    .i_input4_fault_flag_mgmt(i_input4_fault_flag_mgmt), .i_input4_fault_flag_host(i_input4_fault_flag_host),
    .i_input5_fault_flag_mgmt(i_input5_fault_flag_mgmt), .i_input5_fault_flag_host(i_input5_fault_flag_host),
    .o_pwm_full_override(o_pwm_full_override), .o_mgmt_read_clears(o_mgmt_read_clears), .o_tach_edge(o_tach_edge),
    .o_mgmt_record_block(o_mgmt_record_block), .o_host_record_block(o_host_record_block), .o_alert(o_alert));

  // Clock of 10 ns period.
  always #5 i_clk = ~i_clk;

  // Cuts a hung run short.
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Holds reset for two cycles and waits out the internal release.
  task automatic do_reset();
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  // One write strobe; the fields are visible at the falling edge after it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask

  // One read strobe; only this register answers, one cycle later.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    `CHK(o_reg_rvalid, a == STATUS_CONTROL_ADDR)
    if (a == STATUS_CONTROL_ADDR)
      `CHK(o_reg_rdata, exp)
  endtask

  // Main sequence: reset values, table of writes, then awkward cases.
  initial
  begin
    do_reset();
    rd(STATUS_CONTROL_ADDR, STATUS_CONTROL_RESET);
    `CHK({o_pwm_full_override, o_mgmt_read_clears, o_tach_edge, o_alert}, 5'h00)
    i_alert_en = 1'b1;
    foreach (rows[i])
    begin
      i_host_err_any = rows[i].host;
      i_mgmt_err_any = rows[i].mgmt;
      wr(STATUS_CONTROL_ADDR, rows[i].wd);
      rd(STATUS_CONTROL_ADDR, rows[i].exp);
      `CHK(o_pwm_full_override, rows[i].exp[0])
      `CHK(o_mgmt_read_clears, rows[i].exp[1])
      `CHK(o_tach_edge, rows[i].exp[5:4])
      `CHK(o_alert, rows[i].mgmt)
    end
    // Alert stays low when disabled; unmapped addresses neither store nor answer.
    i_alert_en = 1'b0;
    wr(8'hE3, 8'h00);
    rd(8'hE1, 8'h00);
    `CHK(o_alert, 1'b0)
    rd(STATUS_CONTROL_ADDR, 8'hEF);
    i_host_err_any = 1'b0;
    i_mgmt_err_any = 1'b0;
    // Auto-mask on input 4, released flag by flag.
    wr(STATUS_CONTROL_ADDR, 8'h0C);
    i_input4_event = 1'b1;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b11)
    @(negedge i_clk);
    i_input4_event = 1'b0;
    i_input4_fault_flag_mgmt = 1'b1;
    i_input4_fault_flag_host = 1'b1;
    @(negedge i_clk);
    `CHK({o_mgmt_record_block, o_host_record_block}, 2'b11)
    i_input4_fault_flag_mgmt = 1'b0;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b01)
    @(negedge i_clk);
    i_input4_fault_flag_host = 1'b0;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b00)
    // Auto-mask on input 5, then each flag left standing alone.
    @(negedge i_clk);
    i_input5_event = 1'b1;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b11)
    @(negedge i_clk);
    i_input5_event = 1'b0;
    i_input5_fault_flag_host = 1'b1;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b01)
    @(negedge i_clk);
    i_input5_fault_flag_host = 1'b0;
    i_input5_fault_flag_mgmt = 1'b1;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b10)
    @(negedge i_clk);
    i_input5_fault_flag_mgmt = 1'b0;
    // No masking when both enables are clear.
    wr(STATUS_CONTROL_ADDR, 8'h00);
    i_input4_event = 1'b1;
    i_input5_event = 1'b1;
    #1 `CHK({o_mgmt_record_block, o_host_record_block}, 2'b00)
    @(negedge i_clk);
    i_input4_event = 1'b0;
    i_input5_event = 1'b0;
    // Lock freezes the clear-mode bit only; after the lock is dropped and a reset follows, the bit is writable again.
    wr(STATUS_CONTROL_ADDR, 8'h02);
    i_config_lock = 1'b1;
    wr(STATUS_CONTROL_ADDR, 8'h01);
    rd(STATUS_CONTROL_ADDR, 8'h03);
    i_config_lock = 1'b0;
    do_reset();
    rd(STATUS_CONTROL_ADDR, STATUS_CONTROL_RESET);
    wr(STATUS_CONTROL_ADDR, 8'h02);
    rd(STATUS_CONTROL_ADDR, 8'h02);
    print_verdict();
  end
endmodule
`default_nettype wire
